// file: rtl/irs_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module irs_arbiter
    import irs_pkg::*;
(
    // candidate requests
    input wire logic [NSRC-1:0] req,
    // winner
    output logic found,
    output logic [IDW-1:0] idx
);
    // lowest index wins
    function automatic logic [IDW:0] first_set(input logic [NSRC-1:0] v);
        logic [IDW:0] r;
        r = {1'b0, SRC_NONE};
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, IDW'(i)};
            end
        end
        return r;
    endfunction

    wire logic [IDW:0] pick = first_set(req);
    assign found = pick[IDW];
    assign idx = pick[IDW-1:0];
endmodule
`default_nettype wire

// file: rtl/irs_controller.sv
`timescale 1ns/1ps
`default_nettype none
module irs_controller
    import irs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // external pins
    input wire logic ext_request_pin_zero,
    input wire logic ext_request_pin_one,
    input wire logic timer_two_trigger_pin,
    // configuration
    input wire logic ext0_edge_select,
    input wire logic ext1_edge_select,
    input wire logic adc_takeover,
    input wire logic timer_two_trigger_enable,
    input wire logic [1:0] timer_zero_mode,
    input wire logic [7:0] irq_enable_primary,
    input wire logic [7:0] irq_enable_secondary,
    input wire logic [7:0] irq_priority_primary,
    input wire logic [7:0] irq_priority_secondary,
    // peripheral events, one-cycle pulses
    input wire logic timer_zero_overflow,
    input wire logic timer_one_overflow,
    input wire logic timer_two_overflow,
    input wire logic adc_done,
    input wire logic twowire_event,
    input wire logic usb_ep0_tx,
    input wire logic usb_ep0_rx,
    input wire logic usb_ep1_tx,
    input wire logic usb_ep2_tx,
    input wire logic usb_suspend,
    input wire logic usb_resume,
    input wire logic usb_eop,
    // serial port request levels, flags held in the ports
    input wire logic uart1_request,
    input wire logic uart2_request,
    // software clears, one-cycle pulses
    input wire logic sw_clear_timer_two_overflow,
    input wire logic sw_clear_timer_two_trigger,
    input wire logic sw_clear_usb,
    // core handshake
    input wire logic core_ack,
    input wire logic core_reti,
    // to the core
    output logic irq_valid,
    output logic [IDW-1:0] irq_vector,
    output logic irq_high,
    output logic ext0_request_flag,
    output logic ext1_request_flag,
    output logic timer_zero_overflow_flag,
    output logic timer_one_overflow_flag,
    output logic timer_two_overflow_flag,
    output logic timer_two_trigger_flag,
    output logic twowire_request_bit,
    output logic usb_request_flag,
    output logic [1:0] active_level
);
    // pin conditioning
    logic e0_low, e0_fall, e1_low, e1_fall, t2_fall;
    logic e0_edge_cap, e1_edge_cap;

    irs_pin_sync u_sync0 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(ext_request_pin_zero),
        .level_low(e0_low),
        .fall(e0_fall)
    );
    irs_pin_sync u_sync1 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(ext_request_pin_one),
        .level_low(e1_low),
        .fall(e1_fall)
    );
    irs_pin_sync u_sync2 (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(timer_two_trigger_pin),
        .level_low(),
        .fall(t2_fall)
    );

    // acknowledge decode
    wire logic ack_ext0 = core_ack && irq_vector == SRC_EXT0;
    wire logic ack_tmr0 = core_ack && irq_vector == SRC_TMR0;
    wire logic ack_twi = core_ack && irq_vector == SRC_TWI;
    wire logic ack_ext1 = core_ack && irq_vector == SRC_EXT1;
    wire logic ack_tmr1 = core_ack && irq_vector == SRC_TMR1;

    // external request one may be taken over by the converter
    wire logic e1_set_edge = e1_fall || (adc_takeover && adc_done);

    // next flag values, set wins over clear
    wire logic next_ext0 = ext0_edge_select ?
        (e0_fall || (ext0_request_flag && !(ack_ext0 && e0_edge_cap))) : e0_low;
    wire logic next_ext1 = ext1_edge_select ?
        (e1_set_edge || (ext1_request_flag && !(ack_ext1 && e1_edge_cap))) :
        (e1_low || (adc_takeover && adc_done));
    wire logic t0_ovf = timer_zero_overflow && timer_zero_mode != TMR0_MODE3;
    wire logic next_tmr0 = t0_ovf || (timer_zero_overflow_flag && !ack_tmr0);
    wire logic next_tmr1 = timer_one_overflow || (timer_one_overflow_flag && !ack_tmr1);
    wire logic next_tmr2 = timer_two_overflow ||
        (timer_two_overflow_flag && !sw_clear_timer_two_overflow);
    wire logic t2x_set = timer_two_trigger_enable && t2_fall;
    wire logic next_t2x = t2x_set ||
        (timer_two_trigger_flag && !sw_clear_timer_two_trigger);
    wire logic next_twi = twowire_event || (twowire_request_bit && !ack_twi);
    wire logic usb_evt = usb_ep0_tx | usb_ep0_rx | usb_ep1_tx | usb_ep2_tx |
        usb_suspend | usb_resume | usb_eop;
    wire logic next_usb = usb_evt || (usb_request_flag && !sw_clear_usb);

    // request vector in polling order
    wire logic [NSRC-1:0] raw = {
        timer_two_overflow_flag | timer_two_trigger_flag,
        uart1_request,
        usb_request_flag,
        timer_one_overflow_flag,
        1'b0,
        ext1_request_flag,
        twowire_request_bit,
        timer_zero_overflow_flag,
        uart2_request,
        ext0_request_flag
    };
    wire logic [NSRC-1:0] en = {
        irq_enable_primary[EN_TMR2],
        irq_enable_primary[EN_UART1],
        irq_enable_secondary[ENS_USB],
        irq_enable_primary[EN_TMR1],
        1'b0,
        irq_enable_primary[EN_EXT1],
        irq_enable_secondary[ENS_TWI],
        irq_enable_primary[EN_TMR0],
        irq_enable_secondary[ENS_UART2],
        irq_enable_primary[EN_EXT0]
    };
    wire logic [NSRC-1:0] pri = {
        irq_priority_primary[EN_TMR2],
        irq_priority_primary[EN_UART1],
        irq_priority_secondary[ENS_USB],
        irq_priority_primary[EN_TMR1],
        1'b0,
        irq_priority_primary[EN_EXT1],
        irq_priority_secondary[ENS_TWI],
        irq_priority_primary[EN_TMR0],
        irq_priority_secondary[ENS_UART2],
        irq_priority_primary[EN_EXT0]
    };
    wire logic [NSRC-1:0] live = raw & en & {NSRC{irq_enable_primary[EN_GLOBAL]}};

    // level gating: high never preempted, low only by high
    wire logic allow_hi = !active_level[1];
    wire logic allow_lo = active_level == 2'b00;
    wire logic [NSRC-1:0] cand_hi = live & pri & {NSRC{allow_hi}};
    wire logic [NSRC-1:0] cand_lo = live & ~pri & {NSRC{allow_lo}};

    logic hi_found, lo_found;
    logic [IDW-1:0] hi_idx, lo_idx;

    irs_arbiter u_arb_hi (
        .req(cand_hi),
        .found(hi_found),
        .idx(hi_idx)
    );
    irs_arbiter u_arb_lo (
        .req(cand_lo),
        .found(lo_found),
        .idx(lo_idx)
    );

    wire logic next_valid = hi_found || lo_found;
    wire logic [IDW-1:0] next_vector = hi_found ? hi_idx : (lo_found ? lo_idx : SRC_NONE);
    wire logic next_high = hi_found;

    // in-service levels: bit1 high, bit0 low
    wire logic take = core_ack && irq_valid;
    wire logic [1:0] ret_mask = active_level[1] ? 2'b01 : 2'b00;
    wire logic [1:0] next_active = take ? (active_level | (irq_high ? 2'b10 : 2'b01)) :
        (core_reti ? (active_level & ret_mask) : active_level);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ext0_request_flag <= 1'b0;
            ext1_request_flag <= 1'b0;
            timer_zero_overflow_flag <= 1'b0;
            timer_one_overflow_flag <= 1'b0;
            timer_two_overflow_flag <= 1'b0;
            timer_two_trigger_flag <= 1'b0;
            twowire_request_bit <= 1'b0;
            usb_request_flag <= 1'b0;
        end else begin
            ext0_request_flag <= next_ext0;
            ext1_request_flag <= next_ext1;
            timer_zero_overflow_flag <= next_tmr0;
            timer_one_overflow_flag <= next_tmr1;
            timer_two_overflow_flag <= next_tmr2;
            timer_two_trigger_flag <= next_t2x;
            twowire_request_bit <= next_twi;
            usb_request_flag <= next_usb;
        end
    end

    // remember how each external flag was captured
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            e0_edge_cap <= 1'b0;
            e1_edge_cap <= 1'b0;
        end else begin
            e0_edge_cap <= ext0_edge_select;
            e1_edge_cap <= ext1_edge_select;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_valid <= 1'b0;
            irq_vector <= SRC_NONE;
            irq_high <= 1'b0;
            active_level <= 2'b00;
        end else begin
            irq_valid <= next_valid && !take;
            irq_vector <= take ? SRC_NONE : next_vector;
            irq_high <= next_high && !take;
            active_level <= next_active;
        end
    end
endmodule
`default_nettype wire

// file: rtl/irs_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module irs_pin_sync
    import irs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // pin and result
    input wire logic pin,
    output logic level_low,
    output logic fall
);
    logic [SYNC_STAGES:0] sr;

    // pins idle high; first stage read only by the second
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sr <= '1;
        end else begin
            sr <= {sr[SYNC_STAGES-1:0], pin};
        end
    end

    assign level_low = ~sr[SYNC_STAGES-1];
    assign fall = sr[SYNC_STAGES] & ~sr[SYNC_STAGES-1];
endmodule
`default_nettype wire

// file: rtl/irs_pkg.sv
// How it works
// - nine request sources feed the controller, one of the ten slots reserved in the order
// - external request zero is level or falling-edge sensitive by its select bit
// - external request zero reaches the core only through its request flag
// - edge-captured external flags clear when the core vectors to them
// - external request one has its own select bit and request flag
// - converter completion can take over the external request one line
// - timer zero and one overflows set their flags, except timer zero mode 3
// - timer zero and one overflow flags clear when serviced
// - timer two overflow flag is cleared only by software
// - timer two trigger pin, when enabled, sets the trigger flag and request
// - two-wire request bit raises its interrupt and hardware clears it
// - usb events raise the usb request: endpoint packets, suspend, resume, eop
// - each source has a priority bit; high preempts low, never high
// - equal priority resolves by fixed polling order, index zero highest
// - each source needs its enable bit and the global enable
package irs_pkg;
    localparam int NSRC = 10;
    localparam int IDW = 4;
    // polling order indices
    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_UART2 = 4'h1;
    localparam logic [3:0] SRC_TMR0 = 4'h2;
    localparam logic [3:0] SRC_TWI = 4'h3;
    localparam logic [3:0] SRC_EXT1 = 4'h4;
    localparam logic [3:0] SRC_RSVD = 4'h5;
    localparam logic [3:0] SRC_TMR1 = 4'h6;
    localparam logic [3:0] SRC_USB = 4'h7;
    localparam logic [3:0] SRC_UART1 = 4'h8;
    localparam logic [3:0] SRC_TMR2 = 4'h9;
    localparam logic [3:0] SRC_NONE = 4'hF;
    // primary enable/priority fields
    localparam int EN_EXT0 = 0;
    localparam int EN_TMR0 = 1;
    localparam int EN_EXT1 = 2;
    localparam int EN_TMR1 = 3;
    localparam int EN_UART1 = 4;
    localparam int EN_TMR2 = 5;
    localparam int EN_GLOBAL = 7;
    // secondary enable/priority fields
    localparam int ENS_USB = 0;
    localparam int ENS_TWI = 1;
    localparam int ENS_UART2 = 4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] TMR0_MODE3 = 2'h3;
    localparam int SYNC_STAGES = 2;
endpackage

// file: tb/interrupt_request_sources_tb.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_request_sources_tb
    import irs_pkg::*;
;
    logic ref_clk = 1'b0, rst_n = 1'b0, p0 = 1'b1, t2p = 1'b1, e0s = 1'b0, t2e = 1'b0;
    logic p1 = 1'b1, e1s = 1'b1;
    logic [1:0] t0m = 2'h0;
    logic [7:0] enp = 8'hBF, pp = 8'h00, ps = 8'h00;
    logic [9:0] ev = 10'h000, pend = 10'h000;
    logic [6:0] usb = 7'h00;
    logic [3:0] lag = 4'h2;
    logic [31:0] lf = 32'h451228F6;
    int err_count = 0, total_checks = 0, cyc = 0;
    wire logic core_ack, core_reti, ct2, cusb, irq_valid, irq_high;
    wire logic [3:0] irq_vector;
    wire logic [1:0] active_level;
    wire logic [7:0] fl;
    wire logic [9:0] hm = {pp[5], pp[4], ps[0], pp[3], 1'b0, pp[2], ps[1], pp[1], ps[4], pp[0]};
    irs_controller dut_u (.ref_clk, .rst_n, .ext_request_pin_zero(p0),
        .ext_request_pin_one(p1), .timer_two_trigger_pin(t2p), .ext0_edge_select(e0s),
        .ext1_edge_select(e1s), .adc_takeover(1'b1), .timer_two_trigger_enable(t2e),
        .timer_zero_mode(t0m), .irq_enable_primary(enp), .irq_enable_secondary(8'h13),
        .irq_priority_primary(pp), .irq_priority_secondary(ps), .timer_zero_overflow(ev[2]),
        .timer_one_overflow(ev[6]), .timer_two_overflow(ev[9]), .adc_done(ev[4]),
        .twowire_event(ev[3]), .usb_ep0_tx(usb[0]), .usb_ep0_rx(usb[1]), .usb_ep1_tx(usb[2]),
        .usb_ep2_tx(usb[3]), .usb_suspend(usb[4]), .usb_resume(usb[5]), .usb_eop(usb[6]),
        .uart1_request(pend[8]), .uart2_request(pend[1]), .sw_clear_timer_two_overflow(ct2),
        .sw_clear_timer_two_trigger(ct2), .sw_clear_usb(cusb), .core_ack, .core_reti,
        .irq_valid, .irq_vector, .irq_high, .ext0_request_flag(fl[0]),
        .ext1_request_flag(fl[1]), .timer_zero_overflow_flag(fl[2]),
        .timer_one_overflow_flag(fl[3]), .timer_two_overflow_flag(fl[4]),
        .timer_two_trigger_flag(fl[5]), .twowire_request_bit(fl[6]), .usb_request_flag(fl[7]),
        .active_level);
    irs_core_model core_u (.ref_clk, .rst_n, .irq_valid, .irq_vector, .lag, .core_ack,
        .core_reti, .ct2, .cusb);
    always #10 ref_clk = ~ref_clk;
    function automatic logic [31:0] nx(input logic [31:0] s);
        return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
    endfunction
    function automatic logic [3:0] win(input logic [9:0] m);
        for (int i = 0; i < NSRC; i++)
            if (m[i] && (hm[i] || (m & hm) == 10'h000)) return 4'(i);
        return SRC_NONE;
    endfunction
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic fire(input logic [9:0] m, input int k);
        @(negedge ref_clk);
        ev = m;
        usb = m[7] ? 7'h01 << (k % 7) : 7'h00;
        @(negedge ref_clk);
        ev = 10'h000;
        usb = 7'h00;
        // serial port levels rise with the flags that the pulse has just set
        pend = pend | (m & ~{7'h00, t0m == TMR0_MODE3, 2'h0});
    endtask
    task automatic drain();
        while (pend !== 10'h000 || active_level !== 2'h0) @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
        chk(fl[3:0], 4'h0);
        chk(fl[7:4], 4'h0);
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end
    always @(posedge ref_clk) begin
        if (rst_n && core_ack === 1'b1 && irq_valid === 1'b1) begin
            chk(irq_vector, win(pend));
            chk({3'h0, irq_high}, {3'h0, hm[win(pend)]});
            pend[irq_vector] <= 1'b0;
            if (irq_vector == SRC_EXT0) p0 <= 1'b1;
            if (irq_vector == SRC_EXT1) p1 <= 1'b1;
        end
    end
    initial begin
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        chk(irq_vector, SRC_NONE);
        for (int k = 0; k < 40; k++) begin
            lf = nx(nx(nx(lf)));
            {pp, ps} = lf[31:16];
            t0m = lf[11:10];
            lag = 4'h2 + lf[14:12];
            fire(lf[9:0] & 10'h3DE | 10'h080, k);
            drain();
        end
        t0m = 2'h0;
        pp = 8'h02;
        ps = 8'h00;
        lag = 4'hC;
        fire(10'h040, 0);
        repeat (3) @(negedge ref_clk);
        fire(10'h004, 0);
        repeat (3) @(negedge ref_clk);
        chk({2'h0, active_level}, 4'h3);
        drain();
        enp = 8'h3F;
        fire(10'h040, 0);
        repeat (4) @(negedge ref_clk);
        chk({3'h0, irq_valid}, 4'h0);
        enp = 8'hB7;
        repeat (4) @(negedge ref_clk);
        chk({3'h0, irq_valid}, 4'h0);
        enp = 8'hBF;
        drain();
        e0s = 1'b1;
        @(negedge ref_clk);
        p0 = 1'b0;
        pend[0] = 1'b1;
        drain();
        e0s = 1'b0;
        repeat (3) @(negedge ref_clk);
        p0 = 1'b0;
        pend[0] = 1'b1;
        drain();
        t2e = 1'b1;
        @(negedge ref_clk);
        t2p = 1'b0;
        pend[9] = 1'b1;
        drain();
        e1s = 1'b0;
        repeat (3) @(negedge ref_clk);
        p1 = 1'b0;
        pend[4] = 1'b1;
        drain();
        results();
    end
endmodule
`default_nettype wire

// file: tb/irs_controller_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module irs_controller_monitor
    import irs_pkg::*;
(
    // controller inputs
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ext_request_pin_zero,
    input wire logic ext0_edge_select,
    input wire logic [1:0] timer_zero_mode,
    input wire logic [7:0] irq_enable_primary,
    input wire logic timer_zero_overflow,
    input wire logic timer_one_overflow,
    input wire logic sw_clear_timer_two_overflow,
    input wire logic core_ack,
    // controller outputs
    input wire logic irq_valid,
    input wire logic [IDW-1:0] irq_vector,
    input wire logic ext0_request_flag,
    input wire logic timer_zero_overflow_flag,
    input wire logic timer_one_overflow_flag,
    input wire logic timer_two_overflow_flag,
    input wire logic [1:0] active_level
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_t1_set; timer_one_overflow |=> timer_one_overflow_flag; endproperty
    a_t1_set: assert property (p_t1_set) else $error("t1 flag not set");
    property p_t0_m3; timer_zero_overflow && timer_zero_mode == TMR0_MODE3
        && !timer_zero_overflow_flag |=> !timer_zero_overflow_flag; endproperty
    a_t0_m3: assert property (p_t0_m3) else $error("t0 set in mode 3");
    property p_t1_clr; core_ack && irq_valid && irq_vector == SRC_TMR1
        && !timer_one_overflow |=> !timer_one_overflow_flag; endproperty
    a_t1_clr: assert property (p_t1_clr) else $error("t1 flag kept");
    property p_t2_hold; timer_two_overflow_flag && !sw_clear_timer_two_overflow
        |=> timer_two_overflow_flag; endproperty
    a_t2_hold: assert property (p_t2_hold) else $error("t2 flag lost");
    property p_glob; !irq_enable_primary[EN_GLOBAL] |=> !irq_valid; endproperty
    a_glob: assert property (p_glob) else $error("offer while off");
    property p_hblk; active_level[1] |-> !irq_valid; endproperty
    a_hblk: assert property (p_hblk) else $error("offer in high routine");
    property p_e0_edge; ext0_edge_select && $fell(ext_request_pin_zero)
        |-> ##[1:4] ext0_request_flag; endproperty
    a_e0_edge: assert property (p_e0_edge) else $error("edge missed");
    property p_e0_lvl; (!ext0_edge_select && !ext_request_pin_zero) [*5]
        |-> ext0_request_flag; endproperty
    a_e0_lvl: assert property (p_e0_lvl) else $error("level missed");
    c_nest: cover property (active_level == 2'h3);
    c_t2: cover property (irq_valid && irq_vector == SRC_TMR2);
    c_lvl: cover property (core_ack && irq_vector == SRC_EXT0 && !ext0_edge_select);
endmodule
bind irs_controller irs_controller_monitor mon_u (.ref_clk, .rst_n, .ext_request_pin_zero,
    .ext0_edge_select, .timer_zero_mode, .irq_enable_primary, .timer_zero_overflow,
    .timer_one_overflow, .sw_clear_timer_two_overflow, .core_ack, .irq_valid, .irq_vector,
    .ext0_request_flag, .timer_zero_overflow_flag, .timer_one_overflow_flag,
    .timer_two_overflow_flag, .active_level);
`default_nettype wire

// file: tb/irs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module irs_core_model
    import irs_pkg::*;
(
    // core side of the controller
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic irq_valid,
    input wire logic [IDW-1:0] irq_vector,
    input wire logic [3:0] lag,
    // handshake and software clears
    output logic core_ack,
    output logic core_reti,
    output logic ct2,
    output logic cusb
);
    logic [IDW-1:0] v = 4'hF;
    logic done;
    int stk[$];
    initial {core_ack, core_reti, ct2, cusb} = 4'h0;
    always @(negedge ref_clk) begin
        done = stk.size() > 0 && stk[$] == 1;
        ct2 <= core_ack && v == SRC_TMR2;
        cusb <= core_ack && v == SRC_USB;
        core_reti <= done;
        core_ack <= rst_n && irq_valid === 1'b1 && !done;
        if (done) stk.delete(stk.size() - 1);
        else if (stk.size() > 0) stk[$] = stk[$] - 1;
        if (rst_n && irq_valid === 1'b1 && !done) begin
            v = irq_vector;
            stk.push_back(lag);
        end
        if (!rst_n) stk.delete();
    end
endmodule
`default_nettype wire
